// [rtl/pmrs_pkg.sv]
//------------------------------------------------------------
// Overview of operation
// - Stop bit write enters Stop after write
// - Stop halts oscillator, core, digital peripherals
// - Only a reset ends Stop; restart 0x0000
// - Missing clock detector reset ends Stop
// - Suspend bit halts core and internal oscillator
// - Suspend keeps port match; Timer 3 only when externally clocked
// - Four wake events end Suspend
// - Non-reset wake resumes after suspend write
// - Reset ending Suspend restarts at 0x0000
// - Flags 7:2 read/write; mode bits read zero
// - Idle gates only the processor clock
// - Reset halts core, reloads registers, disables timers
// - Reset sets port latches 0xFF with pullups
// - Power-on and monitor resets drive pin low
// - Reset exit: internal oscillator, watchdog, 0x0000
// - Power-on sets flag; other resets clear it
// - Power-on delay added after supply settles
// - Supply below threshold holds reset, drives pin
// - Monitor enable set by power-on, else kept
// - No power-on delay after monitor reset
//------------------------------------------------------------
package pmrs_pkg;

  //----------------------------------------------------------
  // Register addresses
  //----------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87; // Power control
  localparam logic [7:0] ADDR_OSC_CONTROL = 8'hB2; // Internal oscillator control
  localparam logic [7:0] ADDR_SUPPLY_MON = 8'hFF; // Supply monitor control
  localparam logic [7:0] ADDR_RESET_SOURCE = 8'hEF; // Reset source register

  //----------------------------------------------------------
  // Field positions and reset values
  //----------------------------------------------------------
  localparam int BIT_IDLE = 0; // Idle select
  localparam int BIT_STOP = 1; // Stop select
  localparam int GF_LSB = 2; // General purpose flags low bit
  localparam int GF_MSB = 7; // General purpose flags high bit
  localparam int BIT_SUSPEND = 5; // Suspend bit in oscillator control
  localparam int BIT_MON_EN = 7; // Monitor enable
  localparam int BIT_MON_STAT = 6; // Monitor status
  localparam int BIT_POR_FLAG = 1; // Power-on flag / monitor select
  localparam logic [7:0] POWER_CONTROL_RST = 8'h00; // Power control reset
  localparam logic [7:0] OSC_CONTROL_RST = 8'h00; // Oscillator control reset
  localparam logic [7:0] PORT_LATCH_RST = 8'hFF; // Port latch reset value
  localparam logic [15:0] RESET_VECTOR = 16'h0000; // Fetch address after reset
  localparam logic [3:0] WDT_DIV = 4'hC; // Watchdog prescale, divide by 12

  //----------------------------------------------------------
  // Timing
  //----------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 125; // System clock rate
  localparam int POR_DELAY_US = 10000; // Power-on delay, 10 ms
  localparam int POR_DELAY_CYC = POR_DELAY_US * CLK_FREQ_MHZ; // Delay in cycles
  localparam int POR_CNT_W = 21; // Delay counter width

  //----------------------------------------------------------
  // Wake and reset input bundle positions
  //----------------------------------------------------------
  localparam int IN_SUPPLY_OK = 0; // Supply above threshold
  localparam int IN_OTHER_RST = 1; // Other reset sources combined
  localparam int IN_PORT_MATCH = 2; // Port match event
  localparam int IN_T3_OVF = 3; // Timer 3 overflow
  localparam int IN_CMP_LOW = 4; // Comparator low output
  localparam int IN_CS_GT = 5; // Capacitive sense greater-than
  localparam int IN_W = 6; // Bundle width

  //----------------------------------------------------------
  // Controller states
  //----------------------------------------------------------
  typedef enum logic [6:0] {
    ST_POR_HOLD = 7'b000_0001, // Waiting for supply after power-on
    ST_POR_DELAY = 7'b000_0010, // Power-on delay
    ST_RST_HOLD = 7'b000_0100, // Other reset held
    ST_RUN = 7'b000_1000, // Normal execution
    ST_IDLE = 7'b001_0000, // Processor clock gated
    ST_STOP = 7'b010_0000, // Everything halted
    ST_SUSPEND = 7'b100_0000 // Halted, waiting for wake
  } pmrs_state_t;

  // Clock gating outputs
  typedef struct packed {
    logic int_osc; // Internal oscillator run
    logic cpu; // Processor clock
    logic periph; // Digital peripheral clocks
    logic port_match; // Port match logic
    logic timer3; // Timer 3 clock
  } pmrs_clk_t;

  // Reset exit configuration for the core
  typedef struct packed {
    logic sys_reset; // Hold core and registers in reset
    logic sysclk_int; // Select internal oscillator
    logic wdt_en; // Watchdog enabled
    logic [3:0] wdt_div; // Watchdog prescale
    logic [15:0] start_addr; // Fetch address
  } pmrs_rst_t;

endpackage

// [rtl/pmrs_sequencer.sv]
module pmrs_sequencer #(
  parameter int POR_DELAY_CYCLES = pmrs_pkg::POR_DELAY_CYC // Power-on delay length
) (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Power-on reset of the logic
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic sfr_wr, // Register write strobe
  input wire logic [7:0] sfr_wdata, // Register write data
  input wire logic irq_pending, // Enabled interrupt asserted
  input wire logic cmp_wake_en, // Comparator wake source enabled
  input wire logic t3_ext_clk, // Timer 3 clocked from external source
  input wire logic [pmrs_pkg::IN_W-1:0] async_in, // Supply, resets, wakes
  output logic [7:0] sfr_rdata_r, // Register read data
  output pmrs_pkg::pmrs_clk_t clk_en_r, // Clock enables
  output pmrs_pkg::pmrs_rst_t rst_cfg_r, // Reset state to the core
  output logic [7:0] port_latch_r, // Port latch value forced in reset
  output logic port_open_drain_r, // Ports in open-drain mode
  output logic weak_pullup_en_r, // Weak pullups on
  output logic rst_pin_o_r, // Reset pin output level
  output logic rst_pin_oe_r, // Reset pin drive enable
  output logic wake_pulse_r // One-cycle resume from Suspend or Idle
);

  //----------------------------------------------------------
  // Declarations
  //----------------------------------------------------------
  logic [pmrs_pkg::IN_W-1:0] sync1_r; // First synchroniser stage
  logic [pmrs_pkg::IN_W-1:0] sync2_r; // Second synchroniser stage
  pmrs_pkg::pmrs_state_t state_r; // Controller state
  pmrs_pkg::pmrs_state_t state_nxt; // Next state
  logic [pmrs_pkg::POR_CNT_W-1:0] por_cnt_r; // Power-on delay counter
  logic [5:0] gp_flags_r; // General purpose flags
  logic [7:0] osc_ctrl_r; // Oscillator control, suspend bit cleared
  logic mon_en_r; // Supply monitor enable
  logic mon_sel_r; // Monitor selected as reset source
  logic por_flag_r; // Power-on flag
  logic mon_rst_r; // Current reset came from the monitor
  logic supply_ok; // Synchronised supply status
  logic other_rst; // Synchronised other reset request
  logic mon_trip; // Monitor reset condition
  logic wake_evt; // Any non-reset wake event
  logic in_reset; // Any reset state
  logic wr_power_control; // Write to power control
  logic wr_osc; // Write to oscillator control
  logic wr_mon; // Write to monitor control
  logic wr_rsrc; // Write to reset source
  logic stop_req; // Stop select written
  logic idle_req; // Idle select written
  logic susp_req; // Suspend bit written
  logic pin_hold; // Held reset drives the pin

  //----------------------------------------------------------
  // Input synchroniser
  //----------------------------------------------------------
  // Two stages for every pin-level input
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  //----------------------------------------------------------
  // Decode
  //----------------------------------------------------------
  assign supply_ok = sync2_r[pmrs_pkg::IN_SUPPLY_OK];
  assign other_rst = sync2_r[pmrs_pkg::IN_OTHER_RST];
  assign mon_trip = mon_en_r & mon_sel_r & ~supply_ok;
  // Wake sources; comparator only when enabled
  assign wake_evt = sync2_r[pmrs_pkg::IN_PORT_MATCH]
                  | sync2_r[pmrs_pkg::IN_T3_OVF]
                  | (sync2_r[pmrs_pkg::IN_CMP_LOW] & cmp_wake_en)
                  | sync2_r[pmrs_pkg::IN_CS_GT];
  assign in_reset = (state_r == pmrs_pkg::ST_POR_HOLD)
                  | (state_r == pmrs_pkg::ST_POR_DELAY)
                  | (state_r == pmrs_pkg::ST_RST_HOLD);
  assign wr_power_control = sfr_wr & (sfr_addr == pmrs_pkg::ADDR_POWER_CONTROL) & ~in_reset;
  assign wr_osc = sfr_wr & (sfr_addr == pmrs_pkg::ADDR_OSC_CONTROL) & ~in_reset;
  assign wr_mon = sfr_wr & (sfr_addr == pmrs_pkg::ADDR_SUPPLY_MON) & ~in_reset;
  assign wr_rsrc = sfr_wr & (sfr_addr == pmrs_pkg::ADDR_RESET_SOURCE) & ~in_reset;
  // Mode requests
  assign stop_req = wr_power_control & sfr_wdata[pmrs_pkg::BIT_STOP];
  assign idle_req = wr_power_control & sfr_wdata[pmrs_pkg::BIT_IDLE];
  assign susp_req = wr_osc & sfr_wdata[pmrs_pkg::BIT_SUSPEND];
  // Monitor cause is sticky while held
  assign pin_hold = (state_r == pmrs_pkg::ST_RST_HOLD) ? (mon_rst_r | mon_trip)
                                                       : mon_trip;

  //----------------------------------------------------------
  // State machine
  //----------------------------------------------------------
  // Next state; resets take priority over any mode
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pmrs_pkg::ST_POR_HOLD: begin
        // Wait for supply above threshold
        if (supply_ok) begin
          state_nxt = pmrs_pkg::ST_POR_DELAY;
        end
      end
      pmrs_pkg::ST_POR_DELAY: begin
        if (!supply_ok) begin
          // Supply dipped: wait again
          state_nxt = pmrs_pkg::ST_POR_HOLD;
        end else if (por_cnt_r == pmrs_pkg::POR_CNT_W'(POR_DELAY_CYCLES - 1)) begin
          // Delay done
          state_nxt = pmrs_pkg::ST_RUN;
        end
      end
      pmrs_pkg::ST_RST_HOLD: begin
        // Release once every reset cause is gone, no extra delay
        if (!mon_trip && !other_rst) begin
          state_nxt = pmrs_pkg::ST_RUN;
        end
      end
      default: begin
        // Run, Idle, Stop and Suspend all leave on reset
        if (mon_trip || other_rst) begin
          state_nxt = pmrs_pkg::ST_RST_HOLD;
        end else begin
          unique case (state_r)
            pmrs_pkg::ST_RUN: begin
              // Stop wins over Idle
              if (stop_req) begin
                state_nxt = pmrs_pkg::ST_STOP;
              end else if (idle_req) begin
                state_nxt = pmrs_pkg::ST_IDLE;
              end else if (susp_req) begin
                state_nxt = pmrs_pkg::ST_SUSPEND;
              end
            end
            pmrs_pkg::ST_IDLE: begin
              // Enabled interrupt ends Idle
              if (irq_pending) begin
                state_nxt = pmrs_pkg::ST_RUN;
              end
            end
            pmrs_pkg::ST_SUSPEND: begin
              // Synchronised wakes only
              if (wake_evt) begin
                state_nxt = pmrs_pkg::ST_RUN;
              end
            end
            pmrs_pkg::ST_STOP: begin
              // Only the reset branch leaves
              state_nxt = pmrs_pkg::ST_STOP;
            end
            default: begin
              // Bad code: restart
              state_nxt = pmrs_pkg::ST_POR_HOLD;
            end
          endcase
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= pmrs_pkg::ST_POR_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Power-on delay counter
  always_ff @(posedge clk_sys) begin
    if (srst || state_r != pmrs_pkg::ST_POR_DELAY) begin
      por_cnt_r <= '0;
    end else begin
      por_cnt_r <= por_cnt_r + 1'b1;
    end
  end

  // Remember whether the monitor caused the held reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mon_rst_r <= 1'b1;
    end else if (state_nxt == pmrs_pkg::ST_RST_HOLD) begin
      if (state_r == pmrs_pkg::ST_RST_HOLD) begin
        // Sticky, so a mixed reset keeps the pin low
        mon_rst_r <= mon_rst_r | mon_trip;
      end else begin
        // Entry: note the cause
        mon_rst_r <= mon_trip;
      end
    end
  end

  //----------------------------------------------------------
  // Registers
  //----------------------------------------------------------
  // Power control flags; cleared by every reset
  always_ff @(posedge clk_sys) begin
    if (srst || in_reset) begin
      gp_flags_r <= pmrs_pkg::POWER_CONTROL_RST[pmrs_pkg::GF_MSB:pmrs_pkg::GF_LSB];
    end else if (wr_power_control) begin
      gp_flags_r <= sfr_wdata[pmrs_pkg::GF_MSB:pmrs_pkg::GF_LSB];
    end
  end

  // Oscillator control; suspend bit cleared on the write, never stored
  always_ff @(posedge clk_sys) begin
    if (srst || in_reset) begin
      osc_ctrl_r <= pmrs_pkg::OSC_CONTROL_RST;
    end else if (wr_osc) begin
      osc_ctrl_r <= sfr_wdata;
      // Suspend is acted on, not stored
      osc_ctrl_r[pmrs_pkg::BIT_SUSPEND] <= 1'b0;
    end
  end

  // Monitor enable: power-on only sets it, other resets keep it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mon_en_r <= 1'b1;
    end else if (wr_mon) begin
      mon_en_r <= sfr_wdata[pmrs_pkg::BIT_MON_EN];
    end
  end

  // Monitor reset select; software arms it after enabling
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mon_sel_r <= 1'b1;
    end else if (wr_rsrc) begin
      mon_sel_r <= sfr_wdata[pmrs_pkg::BIT_POR_FLAG];
    end
  end

  // Power-on flag: set on power-on exit, cleared by other resets
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      por_flag_r <= 1'b0;
    end else if (state_r == pmrs_pkg::ST_POR_DELAY && state_nxt == pmrs_pkg::ST_RUN) begin
      // Power-on delay finished
      por_flag_r <= 1'b1;
    end else if (state_r == pmrs_pkg::ST_RST_HOLD) begin
      // Any other held reset
      por_flag_r <= 1'b0;
    end
  end

  // Read data; mode select bits always read zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sfr_rdata_r <= '0;
    end else begin
      unique case (sfr_addr)
        pmrs_pkg::ADDR_POWER_CONTROL: sfr_rdata_r <= {gp_flags_r, 2'b00};
        // Suspend bit reads clear
        pmrs_pkg::ADDR_OSC_CONTROL: sfr_rdata_r <= osc_ctrl_r;
        // Enable and live supply status
        pmrs_pkg::ADDR_SUPPLY_MON: sfr_rdata_r <= {mon_en_r, supply_ok, 6'b00_0000};
        // Power-on flag only
        pmrs_pkg::ADDR_RESET_SOURCE: sfr_rdata_r <= {6'b00_0000, por_flag_r, 1'b0};
        default: sfr_rdata_r <= '0;
      endcase
    end
  end

  //----------------------------------------------------------
  // Outputs
  //----------------------------------------------------------
  // Clock enables per state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      clk_en_r <= '0;
    end else begin
      unique case (state_nxt)
        // Run: all clocks
        pmrs_pkg::ST_RUN: clk_en_r <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        // Idle: processor clock gated
        pmrs_pkg::ST_IDLE: clk_en_r <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        // Stop: everything off
        pmrs_pkg::ST_STOP: clk_en_r <= '0;
        // Suspend: port match, maybe Timer 3
        pmrs_pkg::ST_SUSPEND: clk_en_r <= '{1'b0, 1'b0, 1'b0, 1'b1, t3_ext_clk};
        // Reset: oscillator only
        default: clk_en_r <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      endcase
    end
  end

  // Core reset and reset-exit configuration
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rst_cfg_r <= '{1'b1, 1'b1, 1'b1, pmrs_pkg::WDT_DIV, pmrs_pkg::RESET_VECTOR};
    end else begin
      rst_cfg_r.sys_reset <= (state_nxt == pmrs_pkg::ST_POR_HOLD)
                           | (state_nxt == pmrs_pkg::ST_POR_DELAY)
                           | (state_nxt == pmrs_pkg::ST_RST_HOLD);
      rst_cfg_r.sysclk_int <= 1'b1;
      rst_cfg_r.wdt_en <= 1'b1;
      rst_cfg_r.wdt_div <= pmrs_pkg::WDT_DIV;
      rst_cfg_r.start_addr <= pmrs_pkg::RESET_VECTOR;
    end
  end

  // Port state forced during reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      port_latch_r <= pmrs_pkg::PORT_LATCH_RST;
      port_open_drain_r <= 1'b1;
      weak_pullup_en_r <= 1'b1;
    end else if (in_reset) begin
      // Re-forced while held
      port_latch_r <= pmrs_pkg::PORT_LATCH_RST;
      port_open_drain_r <= 1'b1;
      weak_pullup_en_r <= 1'b1;
    end
  end

  // Reset pin driven low for power-on and monitor resets
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rst_pin_o_r <= 1'b0;
      rst_pin_oe_r <= 1'b1;
    end else begin
      rst_pin_o_r <= 1'b0;
      rst_pin_oe_r <= (state_nxt == pmrs_pkg::ST_POR_HOLD)
                    | (state_nxt == pmrs_pkg::ST_POR_DELAY)
                    | ((state_nxt == pmrs_pkg::ST_RST_HOLD) & pin_hold);
    end
  end

  // Resume pulse for a non-reset wake
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wake_pulse_r <= 1'b0;
    end else begin
      wake_pulse_r <= ((state_r == pmrs_pkg::ST_SUSPEND) | (state_r == pmrs_pkg::ST_IDLE))
                    & (state_nxt == pmrs_pkg::ST_RUN);
    end
  end

endmodule

// [tb/pmrs_sequencer_props.sv]
module pmrs_sequencer_props (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Sync reset
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic sfr_wr, // Write strobe
  input wire logic [7:0] sfr_wdata, // Write data
  input wire logic t3_ext_clk, // Timer 3 on external clock
  input wire logic [pmrs_pkg::IN_W-1:0] async_in, // Supply, resets, wakes
  input wire logic [7:0] sfr_rdata_r, // Read data
  input wire pmrs_pkg::pmrs_clk_t clk_en_r, // Clock enables
  input wire pmrs_pkg::pmrs_rst_t rst_cfg_r, // Reset state
  input wire logic rst_pin_o_r, // Reset pin level
  input wire logic rst_pin_oe_r, // Reset pin drive
  input wire logic wake_pulse_r // Resume pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic por_r; // Power-on release still pending
  wire run = clk_en_r.cpu && !rst_cfg_r.sys_reset; // Core executing
  wire wr_pc = sfr_wr && sfr_addr == pmrs_pkg::ADDR_POWER_CONTROL && run; // Mode write

  // Tracks whether the current reset is the power-on one
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      por_r <= 1'b1;
    end else if (!rst_cfg_r.sys_reset) begin
      por_r <= 1'b0;
    end
  end

  property p_mode_read_zero;
    !$past(srst) && $past(sfr_addr) == pmrs_pkg::ADDR_POWER_CONTROL |-> sfr_rdata_r[1:0] == 2'h0;
  endproperty
  a_mode_read_zero: assert property (p_mode_read_zero) else $error("mode bits read set");
  property p_stop_entry;
    wr_pc && sfr_wdata[pmrs_pkg::BIT_STOP] |=> clk_en_r == 5'h00;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");
  property p_stop_hold;
    clk_en_r == 5'h00 && !rst_cfg_r.sys_reset |=> clk_en_r == 5'h00 || rst_cfg_r.sys_reset;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");
  property p_suspend_entry;
    sfr_wr && sfr_addr == pmrs_pkg::ADDR_OSC_CONTROL && sfr_wdata[pmrs_pkg::BIT_SUSPEND] && run
      |=> clk_en_r == {4'h1, $past(t3_ext_clk)};
  endproperty
  a_suspend_entry: assert property (p_suspend_entry) else $error("suspend clocks wrong");
  property p_idle_entry;
    wr_pc && sfr_wdata[1:0] == 2'h1 |=> clk_en_r == 5'h17;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle clocks wrong");
  property p_port_wake;
    !clk_en_r.int_osc && clk_en_r.port_match && !rst_cfg_r.sys_reset
      && $rose(async_in[pmrs_pkg::IN_PORT_MATCH]) |-> ##[1:4] wake_pulse_r;
  endproperty
  a_port_wake: assert property (p_port_wake) else $error("port match did not wake");
  property p_wake_run;
    wake_pulse_r |-> clk_en_r == 5'h1F && !rst_cfg_r.sys_reset;
  endproperty
  a_wake_run: assert property (p_wake_run) else $error("wake without full clocks");
  property p_pin_in_reset;
    rst_pin_oe_r |-> rst_cfg_r.sys_reset && !rst_pin_o_r;
  endproperty
  a_pin_in_reset: assert property (p_pin_in_reset) else $error("pin driven outside reset");
  property p_mon_release;
    !por_r && rst_pin_oe_r && $rose(async_in[pmrs_pkg::IN_SUPPLY_OK])
      |-> ##[1:8] !rst_cfg_r.sys_reset;
  endproperty
  a_mon_release: assert property (p_mon_release) else $error("monitor release slow");
  c_stop: cover property (wr_pc && sfr_wdata[pmrs_pkg::BIT_STOP]);
  c_wake: cover property (wake_pulse_r);
  c_mon: cover property (!por_r && rst_pin_oe_r);
endmodule

bind pmrs_sequencer pmrs_sequencer_props pmrs_sequencer_props_i (
  .clk_sys(clk_sys), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata), .t3_ext_clk(t3_ext_clk), .async_in(async_in),
  .sfr_rdata_r(sfr_rdata_r), .clk_en_r(clk_en_r), .rst_cfg_r(rst_cfg_r),
  .rst_pin_o_r(rst_pin_o_r), .rst_pin_oe_r(rst_pin_oe_r), .wake_pulse_r(wake_pulse_r)
);

// [tb/pmrs_core_model.sv]
module pmrs_core_model (
  input wire logic clk_sys, // System clock
  input wire logic supply_ok, // Supply above threshold
  input wire logic ext_rst, // Pin, clock-loss, watchdog resets
  input wire logic [3:0] wake_req, // Cap-sense, comparator, T3, port match
  output logic [pmrs_pkg::IN_W-1:0] async_in // Levels to the sequencer
);
  // Divider left at divide by 1 whenever Suspend is requested
  localparam logic [2:0] SYSCLK_DIVIDER = 3'h0;

  // Sources launch from their own flops; event lines drop to idle low
  always_ff @(posedge clk_sys) begin
    async_in <= {wake_req, ext_rst, supply_ok};
  end
endmodule

// [tb/pmrs_sequencer_tb.sv]
module pmrs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR_CYC = 20; // Shortened power-on delay
  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} pmrs_row_t;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic irq_pending = 1'b0;
  logic cmp_wake_en = 1'b1;
  logic t3_ext_clk = 1'b1;
  logic supply_ok = 1'b0;
  logic ext_rst = 1'b0;
  logic [3:0] wake_req = 4'h0;
  logic [pmrs_pkg::IN_W-1:0] async_in;
  logic [7:0] sfr_rdata_r;
  pmrs_pkg::pmrs_clk_t clk_en_r;
  pmrs_pkg::pmrs_rst_t rst_cfg_r;
  logic [7:0] port_latch_r;
  logic port_open_drain_r, weak_pullup_en_r, rst_pin_o_r, rst_pin_oe_r, wake_pulse_r;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  // Register writes and readbacks: flags, zero, unmapped, monitor
  pmrs_row_t rows [5] = '{'{8'h87, 8'hFC, 8'hFC}, '{8'h87, 8'h54, 8'h54},
    '{8'h87, 8'h00, 8'h00}, '{8'h30, 8'hAA, 8'h00}, '{8'hFF, 8'h80, 8'hC0}};

  pmrs_sequencer #(.POR_DELAY_CYCLES(POR_CYC)) pmrs_sequencer_i (
    .clk_sys(clk_sys), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .irq_pending(irq_pending), .cmp_wake_en(cmp_wake_en),
    .t3_ext_clk(t3_ext_clk), .async_in(async_in), .sfr_rdata_r(sfr_rdata_r),
    .clk_en_r(clk_en_r), .rst_cfg_r(rst_cfg_r), .port_latch_r(port_latch_r),
    .port_open_drain_r(port_open_drain_r), .weak_pullup_en_r(weak_pullup_en_r),
    .rst_pin_o_r(rst_pin_o_r), .rst_pin_oe_r(rst_pin_oe_r), .wake_pulse_r(wake_pulse_r));
  pmrs_core_model pmrs_core_model_i (.clk_sys(clk_sys), .supply_ok(supply_ok),
    .ext_rst(ext_rst), .wake_req(wake_req), .async_in(async_in));

  always #4 clk_sys = ~clk_sys;

  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail("run too long");
      stop_test();
    end
  end

  task automatic fail(input string m);
    err_total++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) fail(m);
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    step(1);
    sfr_wr = 1'b0;
    step(1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    sfr_addr = a;
    step(1);
    chk(sfr_rdata_r & m, e, "read data");
  endtask
  function automatic bit seen(input int k);
    if (k == 0) return rst_cfg_r.sys_reset === 1'b0;
    if (k == 1) return rst_cfg_r.sys_reset === 1'b1;
    return wake_pulse_r === 1'b1;
  endfunction
  // Bounded wait: 0 run, 1 reset, 2 wake pulse
  task automatic wait_for(input int k, output int c);
    c = 0;
    while (!seen(k) && c < 100) begin
      step(1);
      c++;
    end
    if (c >= 100) fail("wait bound hit");
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    step(16);
    srst = 1'b0;
    chk({rst_cfg_r.sys_reset, rst_pin_oe_r, clk_en_r}, 7'h60, "reset state");
    chk({port_latch_r, port_open_drain_r, weak_pullup_en_r}, 10'h3FF, "ports");
    step(8);
    supply_ok = 1'b1;
    wait_for(0, n);
    chk(n >= POR_CYC && n < POR_CYC + 8, 1, "power-on delay");
    chk({rst_cfg_r.sysclk_int, rst_cfg_r.wdt_en, rst_cfg_r.wdt_div, rst_cfg_r.start_addr,
      clk_en_r}, {2'h3, 4'hC, 16'h0000, 5'h1F}, "reset exit");
    rdchk(8'hEF, 8'h02, 8'h02);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rdchk(rows[i].addr, rows[i].exp, 8'hFF);
    end
    // Idle, woken by an interrupt
    wr(8'h87, 8'h05);
    chk(clk_en_r, 5'h17, "idle clocks");
    irq_pending = 1'b1;
    wait_for(2, n);
    irq_pending = 1'b0;
    chk(clk_en_r, 5'h1F, "idle wake");
    rdchk(8'h87, 8'h04, 8'hFF);
    // Suspend, one wake source each pass
    for (int i = 0; i < 4; i++) begin
      t3_ext_clk = i[0];
      wr(8'hB2, 8'h20);
      chk(clk_en_r, {4'h1, t3_ext_clk}, "suspend clocks");
      wake_req[i] = 1'b1;
      wait_for(2, n);
      wake_req = 4'h0;
      chk(clk_en_r, 5'h1F, "suspend wake");
      step(4); // Drain the synchronised wake
    end
    // Disabled comparator ignored, then a reset ends Suspend
    cmp_wake_en = 1'b0;
    wr(8'hB2, 8'h20);
    wake_req = 4'h4;
    step(8);
    chk(clk_en_r.cpu, 1'b0, "comparator woke");
    wake_req = 4'h0;
    ext_rst = 1'b1;
    wait_for(1, n);
    chk({rst_pin_oe_r, clk_en_r.cpu, clk_en_r.periph}, 3'h0, "other reset");
    ext_rst = 1'b0;
    cmp_wake_en = 1'b1;
    wait_for(0, n);
    chk({clk_en_r, rst_cfg_r.start_addr}, {5'h1F, 16'h0000}, "restart");
    rdchk(8'hEF, 8'h00, 8'h02);
    // Stop ignores wakes; monitor trip ends it
    wr(8'h87, 8'h02);
    chk(clk_en_r, 5'h00, "stop clocks");
    irq_pending = 1'b1;
    wake_req = 4'hF;
    step(8);
    chk(clk_en_r, 5'h00, "stop left");
    irq_pending = 1'b0;
    wake_req = 4'h0;
    supply_ok = 1'b0;
    wait_for(1, n);
    chk({rst_pin_oe_r, rst_pin_o_r}, 2'h2, "pin drive");
    supply_ok = 1'b1;
    wait_for(0, n);
    chk(n < POR_CYC && clk_en_r === 5'h1F, 1, "monitor release");
    // Disabled monitor survives another reset
    wr(8'hFF, 8'h00);
    ext_rst = 1'b1;
    step(6);
    ext_rst = 1'b0;
    wait_for(0, n);
    rdchk(8'hFF, 8'h40, 8'hFF);
    supply_ok = 1'b0;
    step(8);
    chk(rst_cfg_r.sys_reset, 1'b0, "disabled monitor tripped");
    supply_ok = 1'b1;
    step(4);
    // Power-on again: monitor enabled, flag set
    srst = 1'b1;
    step(2);
    srst = 1'b0;
    wait_for(0, n);
    rdchk(8'hFF, 8'hC0, 8'hFF);
    rdchk(8'hEF, 8'h02, 8'h02);
    // Re-arm: enabled but unselected stays quiet
    wr(8'hEF, 8'h00);
    wr(8'hFF, 8'h80);
    supply_ok = 1'b0;
    step(8);
    chk(rst_cfg_r.sys_reset, 1'b0, "unselected monitor tripped");
    supply_ok = 1'b1;
    step(4);
    wr(8'hEF, 8'h02);
    supply_ok = 1'b0;
    wait_for(1, n);
    supply_ok = 1'b1;
    wait_for(0, n);
    chk(n < POR_CYC, 1, "re-armed release");
    rdchk(8'hEF, 8'h00, 8'h02);
    stop_test();
  end
endmodule
